// ===== core/sub_cfg.svh
`ifndef SUB_CFG_SVH
`define SUB_CFG_SVH
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_MASK 8'h08
`define ADDR_FLAGS 8'h0C
`define ADDR_ACC_LO 8'h10
`define ADDR_ACC_HI 8'h20
`define ADDR_ACC_END 8'h30
`define CTRL_SXT 0
`define CTRL_WIDE 1
`define CTRL_SAT 2
`define CTRL_LEGACY 3
`define STATUS_ILLEGAL 4
`define MEM_SHR_OPCODE 8'hDD
`define INSN_BYTES 3
`define FIXED_SHIFT 7'sd16
`define SAT40_POS 40'h7FFFFFFFFF
`define SAT40_NEG 40'h8000000000
`define SAT32_POS 40'h007FFFFFFF
`define SAT32_NEG 40'hFF80000000
`endif

// ===== core/sub_pkg.sv
package sub_pkg;
  typedef enum logic [2:0] {
    OP_ACC_SHR = 3'b000, // dest - (source << count register)
    OP_ACC_SHI = 3'b001, // dest - (source << shift_immediate)
    OP_K16_SHI = 3'b010, // source - (constant << shift_immediate)
    OP_MEM_SHR = 3'b011, // source - (memory << count register)
    OP_MEM_SH16 = 3'b100, // source - (memory << 16), borrow-only carry
    OP_REV_SH16 = 3'b101 // (memory << 16) - source
  } op_kind_e;
  typedef logic [39:0] acc_t;
endpackage : sub_pkg

// ===== core/shifted_accumulator_subtract.sv
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "sub_cfg.svh"
module shifted_accumulator_subtract (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic op_valid,
  input wire sub_pkg::op_kind_e op_kind,
  input wire logic [7:0] op_byte,
  input wire logic [1:0] dst_idx,
  input wire logic [1:0] src_idx,
  input wire logic src_omitted,
  input wire logic [15:0] mem_operand,
  input wire logic [15:0] imm16,
  input wire logic [5:0] shift_immediate,
  input wire logic [15:0] shift_count_register,
  input wire logic repeat_active,
  output logic result_valid,
  output sub_pkg::acc_t result,
  output logic carry_flag,
  output logic [3:0] acc_overflow_flag,
  output logic irq
);
  import sub_pkg::*;

  // widen a 16-bit word to 40 bits
  function automatic acc_t ext16(input logic [15:0] w, input logic sxt);
    ext16 = {(sxt ? {24{w[15]}} : 24'h000000), w};
  endfunction : ext16

  // signed count from the count register
  function automatic logic signed [6:0] reg_count(input logic [15:0] c,
                                                  input logic legacy);
    logic signed [6:0] n;
    n = 7'sd0;
    if (legacy) begin
      n = {c[5], c[5:0]};
      if (n < -7'sd16) begin
        n = n + 7'sd16;
      end
    end else if ($signed(c) > 16'sd31) begin
      n = 7'sd31;
    end else if ($signed(c) < -16'sd32) begin
      n = -7'sd32;
    end else begin
      n = c[6:0];
    end
    reg_count = n;
  endfunction : reg_count

  logic [3:0] mode_reg;
  acc_t acc_reg [4];
  logic [4:0] status_reg, status_next, set_bits, clr_bits;
  logic [4:0] mask_reg;
  logic carry_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic result_valid_reg;
  acc_t result_reg;
  logic irq_reg;

  logic sxt, wide, sat, legacy;
  logic [1:0] src_sel;
  acc_t a_src, a_dst, shift_in, sh40, op_a, op_b, res_next, rev_expect;
  logic signed [6:0] shift_amt;
  logic signed [71:0] wide_val;
  logic shift_ovf, sub_ovf, ovf, borrow, illegal, fire;
  logic [40:0] diff;
  logic apb_acc, apb_wr, apb_setup, addr_ok;
  logic [31:0] rd_next;

  assign sxt = mode_reg[`CTRL_SXT];
  assign wide = mode_reg[`CTRL_WIDE];
  assign sat = mode_reg[`CTRL_SAT];
  assign legacy = mode_reg[`CTRL_LEGACY];
  assign rev_expect = ext16(mem_operand, sxt) << 16;

  // operand fetch; accepted whether or not a repeat loop runs
  always_comb begin
    src_sel = src_omitted ? dst_idx : src_idx;
    a_src = acc_reg[src_sel];
    a_dst = acc_reg[dst_idx];
    illegal = op_valid && (op_kind == OP_MEM_SHR) &&
              (op_byte != `MEM_SHR_OPCODE);
    fire = op_valid && !illegal;
  end

  // shift count and shifted operand
  always_comb begin
    shift_amt = `FIXED_SHIFT;
    shift_in = ext16(mem_operand, sxt);
    case (op_kind)
      OP_ACC_SHR: begin
        shift_amt = reg_count(shift_count_register, legacy);
        shift_in = a_src;
      end
      OP_ACC_SHI: begin
        shift_amt = {shift_immediate[5], shift_immediate};
        shift_in = a_src;
      end
      OP_K16_SHI: begin
        shift_amt = {shift_immediate[5], shift_immediate};
        shift_in = ext16(imm16, sxt);
      end
      OP_MEM_SHR: begin
        shift_amt = reg_count(shift_count_register, legacy);
      end
      default: begin
        shift_amt = `FIXED_SHIFT;
      end
    endcase
    wide_val = {{32{shift_in[39]}}, shift_in};
    if (shift_amt >= 0) begin
      wide_val = wide_val <<< shift_amt;
    end else begin
      wide_val = wide_val >>> (-shift_amt);
    end
    sh40 = wide_val[39:0];
    // legacy mode: shift as if wide, no overflow from the shift
    if (legacy) begin
      shift_ovf = 1'b0;
    end else if (wide) begin
      shift_ovf = !((&wide_val[71:39]) || !(|wide_val[71:39]));
    end else begin
      shift_ovf = !((&wide_val[71:31]) || !(|wide_val[71:31]));
    end
  end

  // 40-bit subtract, borrow, overflow and saturation
  always_comb begin
    op_a = a_src;
    op_b = sh40;
    if (op_kind == OP_ACC_SHR || op_kind == OP_ACC_SHI) begin
      op_a = a_dst;
    end else if (op_kind == OP_REV_SH16) begin
      op_a = sh40;
      op_b = a_src;
    end
    diff = {op_a[39], op_a} - {op_b[39], op_b};
    if (wide) begin
      borrow = op_a < op_b;
      sub_ovf = diff[40] ^ diff[39];
    end else begin
      borrow = op_a[31:0] < op_b[31:0];
      sub_ovf = !((&diff[40:31]) || !(|diff[40:31]));
    end
    ovf = shift_ovf || sub_ovf;
    res_next = diff[39:0];
    if (ovf && sat) begin
      if (wide) begin
        res_next = diff[40] ? `SAT40_NEG : `SAT40_POS;
      end else begin
        res_next = diff[40] ? `SAT32_NEG : `SAT32_POS;
      end
    end
  end

  // accumulators: a running operation wins over a bus write
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < 4; i++) begin
        acc_reg[i] <= 40'h0000000000;
      end
    end else if (fire) begin
      acc_reg[dst_idx] <= res_next;
    end else if (apb_wr && apb_acc) begin
      if (paddr < `ADDR_ACC_HI) begin
        acc_reg[paddr[3:2]][31:0] <= pwdata;
      end else begin
        acc_reg[paddr[3:2]][39:32] <= pwdata[7:0];
      end
    end
  end

  // carry flag
  always_ff @(posedge clk) begin
    if (srst) begin
      carry_reg <= 1'b0;
    end else if (fire) begin
      if (op_kind == OP_MEM_SH16) begin
        if (borrow) begin
          carry_reg <= 1'b0;
        end
      end else begin
        carry_reg <= !borrow;
      end
    end
  end

  // result port
  always_ff @(posedge clk) begin
    if (srst) begin
      result_valid_reg <= 1'b0;
      result_reg <= 40'h0000000000;
    end else begin
      result_valid_reg <= fire;
      if (fire) begin
        result_reg <= res_next;
      end
    end
  end

  // apb decode
  always_comb begin
    apb_setup = psel && !penable;
    apb_wr = psel && penable && pready_reg && pwrite;
    apb_acc = (paddr >= `ADDR_ACC_LO) && (paddr < `ADDR_ACC_END) &&
              (paddr[1:0] == 2'b00);
    addr_ok = apb_acc || paddr == `ADDR_CTRL || paddr == `ADDR_STATUS ||
              paddr == `ADDR_MASK || paddr == `ADDR_FLAGS;
    rd_next = 32'h00000000;
    if (paddr == `ADDR_CTRL) begin
      rd_next = {28'h0000000, mode_reg};
    end else if (paddr == `ADDR_STATUS) begin
      rd_next = {27'h0000000, status_reg};
    end else if (paddr == `ADDR_MASK) begin
      rd_next = {27'h0000000, mask_reg};
    end else if (paddr == `ADDR_FLAGS) begin
      rd_next = {31'h00000000, carry_reg};
    end else if (apb_acc && paddr < `ADDR_ACC_HI) begin
      rd_next = acc_reg[paddr[3:2]][31:0];
    end else if (apb_acc) begin
      rd_next = {24'h000000, acc_reg[paddr[3:2]][39:32]};
    end
  end

  // apb answer: ready in the first access cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= apb_setup;
      pslverr_reg <= apb_setup && !addr_ok;
      if (apb_setup) begin
        prdata_reg <= rd_next;
      end
    end
  end

  // mode and mask registers
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_reg <= 4'h0;
      mask_reg <= 5'h00;
    end else if (apb_wr && paddr == `ADDR_CTRL) begin
      mode_reg <= pwdata[3:0];
    end else if (apb_wr && paddr == `ADDR_MASK) begin
      mask_reg <= pwdata[4:0];
    end
  end

  // status events and write-one clears of this cycle, a new event wins
  always_comb begin
    set_bits = 5'h00;
    clr_bits = 5'h00;
    if (fire && ovf) begin
      set_bits[dst_idx] = 1'b1;
    end
    set_bits[`STATUS_ILLEGAL] = illegal;
    if (apb_wr && paddr == `ADDR_STATUS) begin
      clr_bits = pwdata[4:0];
    end
    status_next = (status_reg & ~clr_bits) | set_bits;
  end

  // sticky status and level interrupt
  always_ff @(posedge clk) begin
    if (srst) begin
      status_reg <= 5'h00;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_reg <= |(status_next & mask_reg);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign result_valid = result_valid_reg;
  assign result = result_reg;
  assign carry_flag = carry_reg;
  assign acc_overflow_flag = status_reg[3:0];
  assign irq = irq_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_fire;
    fire && !(apb_wr && paddr == `ADDR_STATUS);
  endsequence
  sequence s_ovf_fire;
    s_fire ##0 ovf;
  endsequence

  property p_result_width;
    fire |=> result_valid && result == acc_reg[$past(dst_idx)];
  endproperty
  a_result_width: assert property (p_result_width)
    else $error("result not written to destination");

  property p_carry_inv;
    fire && op_kind != OP_MEM_SH16 |=> carry_flag == !$past(borrow);
  endproperty
  a_carry_inv: assert property (p_carry_inv)
    else $error("carry is not the inverse of borrow");

  property p_carry_keep;
    fire && op_kind == OP_MEM_SH16 && !borrow |=> $stable(carry_flag);
  endproperty
  a_carry_keep: assert property (p_carry_keep)
    else $error("carry changed without borrow");

  property p_sat_pos;
    fire && ovf && sat && wide && !diff[40] |=> result == `SAT40_POS;
  endproperty
  a_sat_pos: assert property (p_sat_pos)
    else $error("positive saturation missing");

  property p_ovf_flag;
    s_ovf_fire |=> acc_overflow_flag[$past(dst_idx)] ##1 irq ||
                   !mask_reg[$past(dst_idx, 2)];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag)
    else $error("overflow flag or interrupt missing");

  property p_legacy_shift;
    legacy |-> !shift_ovf;
  endproperty
  a_legacy_shift: assert property (p_legacy_shift)
    else $error("shift overflow flagged in legacy mode");

  property p_legacy_count;
    legacy && (op_kind == OP_ACC_SHR || op_kind == OP_MEM_SHR) |->
      shift_amt >= -7'sd16 && shift_amt <= 7'sd31;
  endproperty
  a_legacy_count: assert property (p_legacy_count)
    else $error("legacy shift count out of range");

  property p_rev;
    fire && op_kind == OP_REV_SH16 && !ovf |=>
      result == $past(rev_expect) - $past(a_src);
  endproperty
  a_rev: assert property (p_rev)
    else $error("reverse form result wrong");

  property p_repeat_issue;
    repeat_active && fire |=> result_valid;
  endproperty
  a_repeat_issue: assert property (p_repeat_issue)
    else $error("op lost inside a repeat loop");
endmodule : shifted_accumulator_subtract
`default_nettype wire

// ===== bench/op_issuer.sv
`timescale 1ns/1ps
`default_nettype none
`include "sub_cfg.svh"
module op_issuer (
  input wire logic clk,
  output logic op_valid,
  output sub_pkg::op_kind_e op_kind,
  output logic [7:0] op_byte,
  output logic [1:0] dst_idx,
  output logic [1:0] src_idx,
  output logic src_omitted,
  output logic [15:0] mem_operand,
  output logic [15:0] imm16,
  output logic [5:0] shift_immediate,
  output logic [15:0] shift_count_register
);
  import sub_pkg::*;
  // idle decoder at time zero
  initial begin
    op_kind = OP_ACC_SHR;
    {op_valid, op_byte, dst_idx, src_idx, src_omitted} = '0;
    {mem_operand, imm16, shift_immediate, shift_count_register} = '0;
  end
  // one-cycle issue; mem_operand and imm16 scrambled once the pulse ends
  task automatic issue(input op_kind_e k, input logic [1:0] d, s,
      input logic om, input logic [15:0] m, i, c,
      input logic [5:0] sh, input logic bad);
    @(posedge clk);
    op_valid <= 1'b1;
    op_kind <= k;
    op_byte <= (k == OP_MEM_SHR && !bad) ? `MEM_SHR_OPCODE : 8'h00;
    dst_idx <= d;
    src_idx <= s;
    src_omitted <= om;
    mem_operand <= m;
    imm16 <= i;
    shift_immediate <= sh;
    shift_count_register <= c;
    @(posedge clk);
    op_valid <= 1'b0;
    mem_operand <= ~m;
    imm16 <= ~i;
  endtask : issue
endmodule : op_issuer
`default_nettype wire

// ===== bench/shifted_accumulator_subtract_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sub_cfg.svh"
module shifted_accumulator_subtract_bench;
  import sub_pkg::*;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, se;
  logic [7:0] paddr, op_byte;
  logic [31:0] pwdata, prdata, q;
  logic op_valid, src_omitted, repeat_active, result_valid, carry_flag, irq;
  op_kind_e op_kind;
  logic [1:0] dst_idx, src_idx;
  logic [15:0] mem_operand, imm16, shift_count_register;
  logic [5:0] shift_immediate;
  logic [3:0] acc_overflow_flag;
  acc_t result;
  int err_count = 0;
  int checked = 0;
  shifted_accumulator_subtract uut (.clk, .srst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .op_valid, .op_kind,
    .op_byte, .dst_idx, .src_idx, .src_omitted, .mem_operand, .imm16,
    .shift_immediate, .shift_count_register, .repeat_active, .result_valid,
    .result, .carry_flag, .acc_overflow_flag, .irq);
  op_issuer dec (.clk, .op_valid, .op_kind, .op_byte, .dst_idx, .src_idx,
    .src_omitted, .mem_operand, .imm16, .shift_immediate,
    .shift_count_register);
  // clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // reporting and compares
  task automatic bad(input string m);
    err_count++;
    $display("MISMATCH at %0t: %s", $time, m);
  endtask : bad
  task automatic cv(input acc_t g, e, input string m);
    checked++;
    if (g !== e) bad(m);
  endtask : cv
  task automatic cb(input logic g, e, input string m);
    checked++;
    if (g !== e) bad(m);
  endtask : cb
  // apb transfer, waits for pready
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) bad("no pready");
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic setacc(input logic [1:0] n, input acc_t v);
    apb(1'b1, `ADDR_ACC_LO + {4'h0, n, 2'b00}, v[31:0]);
    apb(1'b1, `ADDR_ACC_HI + {4'h0, n, 2'b00}, {24'h0, v[39:32]});
  endtask : setacc
  // issue one op and judge its answer
  task automatic op(input op_kind_e k, input logic [1:0] d, s,
      input logic om, input logic [15:0] m, i, c, input logic [5:0] sh,
      input acc_t e, input logic cy);
    dec.issue(k, d, s, om, m, i, c, sh, 1'b0);
    @(negedge clk);
    cb(result_valid, 1'b1, "no result pulse");
    cv(result, e, "result");
    cb(carry_flag, cy, "carry");
  endtask : op
  task automatic t_regs;
    apb(1'b0, `ADDR_CTRL, 32'h0);
    cv({8'h00, q}, 40'h0, "ctrl after reset");
    apb(1'b0, 8'h40, 32'h0);
    cb(se, 1'b1, "unmapped not refused");
    $display("test regs done");
  endtask : t_regs
  task automatic t_shift;
    apb(1'b1, `ADDR_CTRL, 32'h0);
    setacc(0, 40'h1000);
    setacc(1, 40'h1);
    op(OP_ACC_SHI, 0, 1, 0, 0, 0, 0, 6'd4, 40'hFF0, 1'b1);
    apb(1'b1, `ADDR_CTRL, 32'h2);
    setacc(0, 40'h0100000000);
    op(OP_ACC_SHI, 0, 1, 0, 0, 0, 0, 6'd31, 40'h0080000000, 1'b1);
    $display("test shift done");
  endtask : t_shift
  task automatic t_const;
    apb(1'b1, `ADDR_CTRL, 32'h1);
    setacc(2, 40'h0);
    setacc(3, 40'h5);
    op(OP_K16_SHI, 2, 3, 1, 0, 16'h8000, 0, 0, 40'h8000, 1'b0);
    apb(1'b1, `ADDR_CTRL, 32'h0);
    setacc(2, 40'h0);
    op(OP_K16_SHI, 2, 3, 1, 0, 16'h8000, 0, 0, 40'hFFFFFF8000, 1'b0);
    $display("test const done");
  endtask : t_const
  task automatic t_count;
    apb(1'b1, `ADDR_CTRL, 32'h1);
    setacc(0, 40'h0);
    op(OP_MEM_SHR, 1, 0, 0, 16'hFF00, 0, 16'hFFFC, 0, 40'h10, 1'b0);
    dec.issue(OP_MEM_SHR, 1, 0, 0, 16'h1, 0, 0, 0, 1'b1);
    @(negedge clk);
    cb(result_valid, 1'b0, "bad opcode ran");
    apb(1'b0, `ADDR_STATUS, 32'h0);
    cb(q[`STATUS_ILLEGAL], 1'b1, "bad opcode unflagged");
    apb(1'b1, `ADDR_CTRL, 32'h8);
    setacc(1, 40'h30000);
    setacc(3, 40'h10);
    op(OP_ACC_SHR, 3, 1, 0, 0, 0, 16'hFFE0, 0, 40'hD, 1'b1);
    $display("test count done");
  endtask : t_count
  task automatic t_mem16;
    apb(1'b1, `ADDR_CTRL, 32'h0);
    setacc(0, 40'h10);
    op(OP_REV_SH16, 1, 0, 0, 16'h1, 0, 0, 0, 40'hFFF0, 1'b1);
    op(OP_MEM_SH16, 2, 1, 0, 16'h0, 0, 0, 0, 40'hFFF0, 1'b1);
    op(OP_MEM_SH16, 2, 0, 0, 16'h1, 0, 0, 0, 40'hFFFFFF0010, 1'b0);
    $display("test mem16 done");
  endtask : t_mem16
  task automatic t_sat;
    apb(1'b1, `ADDR_STATUS, 32'h1F);
    apb(1'b1, `ADDR_CTRL, 32'h4);
    setacc(0, 40'hFF80000000);
    setacc(1, 40'h1);
    op(OP_ACC_SHI, 0, 1, 0, 0, 0, 0, 0, 40'hFF80000000, 1'b1);
    cb(acc_overflow_flag[0], 1'b1, "overflow flag");
    repeat (2) @(posedge clk);
    cb(irq, 1'b0, "masked irq");
    apb(1'b1, `ADDR_MASK, 32'h1);
    repeat (2) @(posedge clk);
    cb(irq, 1'b1, "irq");
    apb(1'b1, `ADDR_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    cb(irq, 1'b0, "irq after clear");
    apb(1'b1, `ADDR_CTRL, 32'h6);
    setacc(0, 40'hFF80000000);
    op(OP_ACC_SHI, 0, 1, 0, 0, 0, 0, 0, 40'hFF7FFFFFFF, 1'b1);
    cb(acc_overflow_flag[0], 1'b0, "wide overflow");
    $display("test sat done");
  endtask : t_sat
  task automatic t_rep;
    apb(1'b1, `ADDR_CTRL, 32'h0);
    setacc(0, 40'h100);
    repeat_active <= 1'b1;
    op(OP_ACC_SHI, 0, 1, 0, 0, 0, 0, 6'd4, 40'hF0, 1'b1);
    op(OP_ACC_SHI, 0, 1, 0, 0, 0, 0, 6'd4, 40'hE0, 1'b1);
    @(posedge clk);
    repeat_active <= 1'b0;
    $display("test repeat done");
  endtask : t_rep
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  // reset then scenarios
  initial begin
    {srst, psel, penable, pwrite, repeat_active} = 5'b10000;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    t_regs;
    t_shift;
    t_const;
    t_count;
    t_mem16;
    t_sat;
    t_rep;
    final_report;
  end
  // watchdog
  initial begin
    #125000;
    bad("timeout");
    final_report;
  end
endmodule : shifted_accumulator_subtract_bench
`default_nettype wire
